// ---- hw/uotg_regs.sv ----
// Design decisions made here: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
// Functional notes
// - bits 31:8 of enable and status registers always read zero
// - enable bit 1, status bits 6,4,1 read zero; writes ignored
// - enable bit 7 rw, reset 0, gates cable id change interrupt
// - enable bit 6 rw, reset 0, gates millisecond timer interrupt
// - enable bit 5 rw, reset 0, gates line stable interrupt
// - enable bit 4 rw, reset 0, gates bus activity wake interrupt
// - enable bit 3 rw, reset 0, gates session valid change interrupt
// - enable bit 2 rw, reset 0, gates b session end interrupt
// - enable bit 0 rw, reset 0, gates a vbus valid interrupt
// - status bit 7 shows cable id: 1 none or B, 0 type A
// - status bit 5 set only when se0 and j state unchanged 1 ms
// - status bit 3 high while vbus above session valid threshold
// - status bit 2 high while vbus below b session threshold
// - status bit 0 high while vbus above a device valid threshold
// - event flags set by hardware, cleared by writing one
// - millisecond timer flag set when the 1 ms timer expires
module uotg_regs (
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic cable_id_i,
  input wire logic line_se0_i,
  input wire logic line_j_state_i,
  input wire logic bus_activity_i,
  input wire logic session_valid_i,
  input wire logic b_session_end_i,
  input wire logic a_vbus_valid_i,
  output logic otg_irq_o
);

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [3:0] addr, input logic [3:0] reg_addr);
    hit = (addr == reg_addr);
  endfunction

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  // 0x0 event flags: hardware sets, a written one clears, set wins
  // 0x4 otg_interrupt_enable: bits 7..2 and 0 read/write
  // 0x8 otg_live_status: read only, one cycle behind the pins
  // 0xc spare read/write word, kept for software, gates nothing
  // all words: bits 31:8 and unmapped addresses read zero
  // only byte lane 0 carries implemented bits
  // one wait cycle per access keeps read data registered

  uotg_pkg::uotg_pins_t pins;
  uotg_pkg::uotg_avreq_t req;
  logic [7:0] otg_interrupt_enable;
  logic [7:0] otg_live_status;
  logic [7:0] flags;
  logic [7:0] irq_mask;
  logic [7:0] next_status;
  logic [7:0] events;
  logic [7:0] level_changes;
  logic [7:0] wr_byte0;
  logic line_stable;
  logic ms_tick;
  logic served;
  logic accept;
  logic next_irq;

  // all checks below share this clock and reset
  default clocking cb_sys @(posedge sys_clk_i);
  endclocking
  default disable iff (!arst_n_i);

  assign pins = '{cable_id: cable_id_i, line_se0: line_se0_i, line_j_state: line_j_state_i,
                  bus_activity: bus_activity_i, session_valid: session_valid_i,
                  b_session_end: b_session_end_i, a_vbus_valid: a_vbus_valid_i};
  assign req = '{read: avs_read_i, write: avs_write_i, address: avs_address_i,
                 writedata: avs_writedata_i};

  // only byte lane 0 holds implemented bits
  assign wr_byte0 = avs_byteenable_i[0] ? req.writedata[7:0] : 8'h00;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  uotg_line_timer u_line_timer (
    .sys_clk_i(sys_clk_i),
    .arst_n_i(arst_n_i),
    .se0_i(pins.line_se0),
    .j_state_i(pins.line_j_state),
    .stable_o(line_stable),
    .ms_tick_o(ms_tick)
  );

  uotg_edge_detect #(.W(8)) u_edges (
    .sys_clk_i(sys_clk_i),
    .arst_n_i(arst_n_i),
    .level_i(next_status),
    .change_o(level_changes)
  );

  // ----------------------------------------------------------------
  // live status
  // ----------------------------------------------------------------
  // unimplemented positions stay zero
  always_comb begin
    next_status = 8'h00;
    next_status[uotg_pkg::BIT_CABLE_ID] = pins.cable_id;
    next_status[uotg_pkg::BIT_LINE_STABLE] = line_stable;
    next_status[uotg_pkg::BIT_SESSION_VALID] = pins.session_valid;
    next_status[uotg_pkg::BIT_B_SESSION_END] = pins.b_session_end;
    next_status[uotg_pkg::BIT_A_VBUS_VALID] = pins.a_vbus_valid;
  end

  // sampled every cycle, bus writes never reach it
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      otg_live_status <= uotg_pkg::STATUS_RESET;
    end else begin
      otg_live_status <= next_status & uotg_pkg::STATUS_MASK;
    end
  end

  // ----------------------------------------------------------------
  // event sources
  // ----------------------------------------------------------------
  // line stable flag only on reaching stability, not on losing it
  always_comb begin
    events = 8'h00;
    events[uotg_pkg::BIT_CABLE_ID] = level_changes[uotg_pkg::BIT_CABLE_ID];
    events[uotg_pkg::BIT_MS_TIMER] = ms_tick;
    events[uotg_pkg::BIT_LINE_STABLE] = level_changes[uotg_pkg::BIT_LINE_STABLE] & line_stable;
    events[uotg_pkg::BIT_BUS_ACTIVITY] = pins.bus_activity;
    events[uotg_pkg::BIT_SESSION_VALID] = level_changes[uotg_pkg::BIT_SESSION_VALID];
    events[uotg_pkg::BIT_B_SESSION_END] = level_changes[uotg_pkg::BIT_B_SESSION_END];
    events[uotg_pkg::BIT_A_VBUS_VALID] = level_changes[uotg_pkg::BIT_A_VBUS_VALID];
  end

  // ----------------------------------------------------------------
  // avalon slave: one wait cycle, answer on the second edge
  // ----------------------------------------------------------------
  assign accept = (req.read | req.write) & served;

  // waitrequest falls one cycle after the request, then pulses high again
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      served <= 1'b0;
      avs_waitrequest_o <= 1'b1;
    end else begin
      served <= (req.read | req.write) & !served;
      avs_waitrequest_o <= !((req.read | req.write) & !served);
    end
  end

  // enable register, written only at the accepting edge
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      otg_interrupt_enable <= uotg_pkg::ENABLE_RESET;
    end else if (accept && req.write && hit(req.address, uotg_pkg::ADDR_ENABLE)) begin
      otg_interrupt_enable <= wr_byte0 & uotg_pkg::ENABLE_MASK;
    end
  end

  // spare word, same layout as flags; readable, gates nothing
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_mask <= uotg_pkg::IRQ_MASK_RESET;
    end else if (accept && req.write && hit(req.address, uotg_pkg::ADDR_IRQ_MASK)) begin
      irq_mask <= wr_byte0 & uotg_pkg::FLAG_MASK;
    end
  end

  // sticky flags: a new event beats a write-one clear in the same cycle
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      flags <= uotg_pkg::FLAG_RESET;
    end else if (accept && req.write && hit(req.address, uotg_pkg::ADDR_FLAGS)) begin
      flags <= ((flags & ~wr_byte0) | events) & uotg_pkg::FLAG_MASK;
    end else begin
      flags <= (flags | events) & uotg_pkg::FLAG_MASK;
    end
  end

  // read mux; upper 24 bits and unmapped addresses read zero
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      avs_readdata_o <= uotg_pkg::UNMAPPED_READ;
    end else if ((req.read | req.write) && !served) begin
      case (req.address)
        uotg_pkg::ADDR_FLAGS: avs_readdata_o <= {24'h000000, flags};
        uotg_pkg::ADDR_ENABLE: avs_readdata_o <= {24'h000000, otg_interrupt_enable};
        uotg_pkg::ADDR_STATUS: avs_readdata_o <= {24'h000000, otg_live_status};
        uotg_pkg::ADDR_IRQ_MASK: avs_readdata_o <= {24'h000000, irq_mask};
        default: avs_readdata_o <= uotg_pkg::UNMAPPED_READ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // interrupt output
  // ----------------------------------------------------------------
  // registered, so it trails the flag by one cycle; the spare word is not in
  // the path, so an enabled flag alone raises the request
  assign next_irq = |(flags & otg_interrupt_enable);

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      otg_irq_o <= 1'b0;
    end else begin
      otg_irq_o <= next_irq;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // read data, field masks and unimplemented positions
  a_upper_bits_zero: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    avs_readdata_o[31:8] == 24'h000000)
    else $error("upper read bits not zero");

  a_unimpl_zero: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    !otg_interrupt_enable[1] && !otg_live_status[6] && !otg_live_status[4] && !otg_live_status[1])
    else $error("unimplemented bit set");

  a_enable_write: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    accept && req.write && hit(req.address, uotg_pkg::ADDR_ENABLE) && avs_byteenable_i[0]
    |=> otg_interrupt_enable == ($past(req.writedata[7:0]) & uotg_pkg::ENABLE_MASK))
    else $error("enable write not stored");

  a_enable_hold: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    !(accept && req.write && hit(req.address, uotg_pkg::ADDR_ENABLE)) |=> $stable(otg_interrupt_enable))
    else $error("enable changed without write");

  // the first edge after reset still shows the reset value, so skip it
  a_status_tracks: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    $past(arst_n_i) |-> otg_live_status[7] == $past(cable_id_i) && otg_live_status[3] == $past(session_valid_i)
    && otg_live_status[2] == $past(b_session_end_i) && otg_live_status[0] == $past(a_vbus_valid_i))
    else $error("status does not track inputs");

  a_status_line: assert property (
    $past(arst_n_i) |-> otg_live_status[uotg_pkg::BIT_LINE_STABLE] == $past(line_stable))
    else $error("line stable status does not track");

  a_status_wr_ignored: assert property (
    accept && req.write && hit(req.address, uotg_pkg::ADDR_STATUS)
    |=> $stable(otg_interrupt_enable) && $stable(irq_mask))
    else $error("status write reached a register");

  // each answer carries the word as it stood when the request was armed
  a_enable_read: assert property (
    !avs_waitrequest_o && req.read && hit(req.address, uotg_pkg::ADDR_ENABLE)
    |-> avs_readdata_o == {24'h000000, otg_interrupt_enable})
    else $error("enable read data wrong");

  a_status_read: assert property (
    !avs_waitrequest_o && req.read && hit(req.address, uotg_pkg::ADDR_STATUS)
    |-> avs_readdata_o == {24'h000000, $past(otg_live_status)})
    else $error("status read data wrong");

  a_flags_read: assert property (
    !avs_waitrequest_o && req.read && hit(req.address, uotg_pkg::ADDR_FLAGS)
    |-> avs_readdata_o == {24'h000000, $past(flags)})
    else $error("flag read data wrong");

  // every event source lands in its own sticky flag
  a_flag_sticky: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    events[uotg_pkg::BIT_MS_TIMER] |=> flags[uotg_pkg::BIT_MS_TIMER])
    else $error("event lost");

  a_cable_flag: assert property (
    events[uotg_pkg::BIT_CABLE_ID] |=> flags[uotg_pkg::BIT_CABLE_ID])
    else $error("cable id flag not set");

  a_line_flag: assert property (
    events[uotg_pkg::BIT_LINE_STABLE] |=> flags[uotg_pkg::BIT_LINE_STABLE])
    else $error("line stable flag not set");

  a_activity_flag: assert property (
    events[uotg_pkg::BIT_BUS_ACTIVITY] |=> flags[uotg_pkg::BIT_BUS_ACTIVITY])
    else $error("bus activity flag not set");

  a_session_flag: assert property (
    events[uotg_pkg::BIT_SESSION_VALID] |=> flags[uotg_pkg::BIT_SESSION_VALID])
    else $error("session valid flag not set");

  a_bend_flag: assert property (
    events[uotg_pkg::BIT_B_SESSION_END] |=> flags[uotg_pkg::BIT_B_SESSION_END])
    else $error("b session end flag not set");

  a_avbus_flag: assert property (
    events[uotg_pkg::BIT_A_VBUS_VALID] |=> flags[uotg_pkg::BIT_A_VBUS_VALID])
    else $error("a vbus valid flag not set");

  a_ms_flag_quiet: assert property (
    !flags[uotg_pkg::BIT_MS_TIMER] && !events[uotg_pkg::BIT_MS_TIMER]
    |=> !flags[uotg_pkg::BIT_MS_TIMER])
    else $error("timer flag set with no expiry");

  // clearing: a one clears, a zero leaves the flag alone
  a_flag_clear: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    accept && req.write && hit(req.address, uotg_pkg::ADDR_FLAGS) && avs_byteenable_i[0]
    && req.writedata[uotg_pkg::BIT_CABLE_ID] && !events[uotg_pkg::BIT_CABLE_ID]
    |=> !flags[uotg_pkg::BIT_CABLE_ID])
    else $error("flag not cleared by write one");

  a_clear_keeps: assert property (
    accept && req.write && hit(req.address, uotg_pkg::ADDR_FLAGS)
    && !req.writedata[uotg_pkg::BIT_LINE_STABLE] && flags[uotg_pkg::BIT_LINE_STABLE]
    |=> flags[uotg_pkg::BIT_LINE_STABLE])
    else $error("write zero cleared a flag");

  // interrupt request follows enabled flags one cycle late
  a_irq_level: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    ##1 otg_irq_o == $past(|(flags & otg_interrupt_enable)))
    else $error("irq does not follow enabled flags");

  a_irq_rises: assert property (
    (|(flags & otg_interrupt_enable)) |=> otg_irq_o)
    else $error("irq missing for an enabled flag");

  a_irq_clears: assert property (
    !(|(flags & otg_interrupt_enable)) |=> !otg_irq_o)
    else $error("irq high with no enabled flag");

  // bus handshake: one wait cycle, one answer cycle, data held while idle
  a_wait_answer: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("waitrequest held too long");

  a_wait_one_cycle: assert property (
    !avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low for two cycles");

  a_readdata_hold: assert property (
    !(req.read || req.write) |=> $stable(avs_readdata_o))
    else $error("read data moved while idle");

endmodule // uotg_regs

// ---- hw/uotg_pkg.sv ----
package uotg_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses, word aligned)
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_FLAGS = 4'h0;
  localparam logic [3:0] ADDR_ENABLE = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h8;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'hc;

  // ----------------------------------------------------------------
  // field positions (shared by flags, enable, status)
  // ----------------------------------------------------------------
  localparam int BIT_CABLE_ID = 7;
  localparam int BIT_MS_TIMER = 6;
  localparam int BIT_LINE_STABLE = 5;
  localparam int BIT_BUS_ACTIVITY = 4;
  localparam int BIT_SESSION_VALID = 3;
  localparam int BIT_B_SESSION_END = 2;
  localparam int BIT_A_VBUS_VALID = 0;

  // implemented bits
  localparam logic [7:0] ENABLE_MASK = 8'hfd;
  localparam logic [7:0] STATUS_MASK = 8'had;
  localparam logic [7:0] FLAG_MASK = 8'hfd;

  // reset values
  localparam logic [7:0] ENABLE_RESET = 8'h00;
  localparam logic [7:0] FLAG_RESET = 8'h00;
  localparam logic [7:0] IRQ_MASK_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 50_000_000;
  localparam int STABLE_TIME_US = 1000;
  localparam int STABLE_CYCLES = (CLK_HZ / 1_000_000) * STABLE_TIME_US;
  localparam int MS_TIMER_CYCLES = STABLE_CYCLES;
  localparam int CNT_W = 16;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic cable_id;
    logic line_se0;
    logic line_j_state;
    logic bus_activity;
    logic session_valid;
    logic b_session_end;
    logic a_vbus_valid;
  } uotg_pins_t;

  typedef struct packed {
    logic read;
    logic write;
    logic [3:0] address;
    logic [31:0] writedata;
  } uotg_avreq_t;

endpackage

// ---- hw/uotg_line_timer.sv ----
`timescale 1ns/1ps
// ------------------------------------------------------------------
// line-state stability counter and free 1 ms tick
// ------------------------------------------------------------------
module uotg_line_timer #(
  parameter int STABLE_CYCLES = uotg_pkg::STABLE_CYCLES
) (
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic se0_i,
  input wire logic j_state_i,
  output logic stable_o,
  output logic ms_tick_o
);

  localparam logic [uotg_pkg::CNT_W-1:0] LAST = uotg_pkg::CNT_W'(STABLE_CYCLES - 1);

  logic [1:0] line_prev;
  logic [uotg_pkg::CNT_W-1:0] stable_cnt;
  logic [uotg_pkg::CNT_W-1:0] tick_cnt;
  logic changed;

  assign changed = ({se0_i, j_state_i} != line_prev);

  // previous line sample for change detection
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      line_prev <= 2'h0;
    end else begin
      line_prev <= {se0_i, j_state_i};
    end
  end

  // any change restarts the 1 ms window; saturates once stable
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      stable_cnt <= '0;
      stable_o <= 1'b0;
    end else if (changed) begin
      stable_cnt <= '0;
      stable_o <= 1'b0;
    end else if (stable_cnt == LAST) begin
      stable_o <= 1'b1;
    end else begin
      stable_cnt <= stable_cnt + 1'b1;
    end
  end

  // free running millisecond timer, one-cycle tick on expiry
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tick_cnt <= '0;
      ms_tick_o <= 1'b0;
    end else if (tick_cnt == LAST) begin
      tick_cnt <= '0;
      ms_tick_o <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 1'b1;
      ms_tick_o <= 1'b0;
    end
  end

  a_stable_after_ms: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    $rose(stable_o) |-> $past(stable_cnt) == LAST)
    else $error("line stable rose before full window");

  a_stable_drop_change: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    changed |=> !stable_o)
    else $error("line stable held across a change");

endmodule // uotg_line_timer

// ---- hw/uotg_edge_detect.sv ----
`timescale 1ns/1ps
// ------------------------------------------------------------------
// change detector for the live status inputs
// ------------------------------------------------------------------
module uotg_edge_detect #(
  parameter int W = 8
) (
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic [W-1:0] level_i,
  output logic [W-1:0] change_o
);

  logic [W-1:0] prev;
  logic primed;

  // first sample after reset only primes, so reset itself is no event
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      prev <= '0;
      primed <= 1'b0;
    end else begin
      prev <= level_i;
      primed <= 1'b1;
    end
  end

  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      assign change_o[g] = primed & (level_i[g] ^ prev[g]);
    end
  endgenerate

endmodule // uotg_edge_detect

// ---- dv/uotg_far_side.sv ----
`timescale 1ns/1ps
// ------------------------------------------------------------------
// far side: cable id pin, transceiver line state, vbus comparators
// ------------------------------------------------------------------
module uotg_far_side (
  input wire logic sys_clk_i,
  input wire logic cable_a_i,
  input wire logic [1:0] vbus_lvl_i,
  input wire logic se0_i,
  input wire logic j_i,
  input wire logic activity_i,
  output uotg_pkg::uotg_pins_t pins_o
);
  // vbus is one level against ordered thresholds, so the three comparators
  // can never disagree the way a broken bench might make them
  always_ff @(posedge sys_clk_i) begin
    pins_o.cable_id <= !cable_a_i;
    pins_o.session_valid <= (vbus_lvl_i != 2'h0);
    pins_o.b_session_end <= (vbus_lvl_i == 2'h0);
    pins_o.a_vbus_valid <= (vbus_lvl_i == 2'h2);
    pins_o.line_se0 <= se0_i;
    pins_o.line_j_state <= j_i;
    pins_o.bus_activity <= activity_i;
  end
endmodule // uotg_far_side

// ---- dv/uotg_regs_tb.sv ----
`timescale 1ns/1ps
module uotg_regs_tb;
  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  logic sys_clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [3:0] addr = 4'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic wait_req;
  logic irq;
  logic cable_a = 1'b0;
  logic [1:0] vbus = 2'h0;
  logic se0 = 1'b0;
  logic jst = 1'b1;
  logic act = 1'b0;
  uotg_pkg::uotg_pins_t pins;
  int bad_count = 0;
  int n_compared = 0;
  logic [31:0] q;
  int bits[5] = '{7, 3, 2, 0, 4};

  always #10 sys_clk_i = ~sys_clk_i;

  uotg_far_side far (
    .sys_clk_i(sys_clk_i), .cable_a_i(cable_a), .vbus_lvl_i(vbus),
    .se0_i(se0), .j_i(jst), .activity_i(act), .pins_o(pins)
  );

  uotg_regs dut (
    .sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .avs_address_i(addr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
    .avs_byteenable_i(4'hf), .avs_readdata_o(rdata), .avs_waitrequest_o(wait_req),
    .cable_id_i(pins.cable_id), .line_se0_i(pins.line_se0),
    .line_j_state_i(pins.line_j_state), .bus_activity_i(pins.bus_activity),
    .session_valid_i(pins.session_valid), .b_session_end_i(pins.b_session_end),
    .a_vbus_valid_i(pins.a_vbus_valid), .otg_irq_o(irq)
  );

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic give_verdict();
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask

  // one avalon cycle; starts on a fresh edge so no signal is set twice in a step
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk_i);
    addr <= a;
    wr <= w;
    rd <= !w;
    wdata <= d;
    // values read at the edge are the ones the slave presents to that edge
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (wait_req !== 1'b0 && n < 40);
    if (wait_req !== 1'b0) begin
      bad_count++;
      $display("ERROR waitrequest expected 0 seen %b", wait_req);
      give_verdict();
    end else begin
      q = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
    end
  endtask

  task automatic rchk(input string what, input logic [3:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(what, exp, q);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rchk("enable", uotg_pkg::ADDR_ENABLE, 32'h0);
    rchk("status", uotg_pkg::ADDR_STATUS, 32'h84);
    rchk("flags", uotg_pkg::ADDR_FLAGS, 32'h0);
    chk("irq", 32'h0, {31'h0, irq});
  endtask

  task automatic t_access();
    bus(1'b1, uotg_pkg::ADDR_ENABLE, 32'hffff_ffff);
    rchk("enable ones", uotg_pkg::ADDR_ENABLE, 32'hfd);
    bus(1'b1, uotg_pkg::ADDR_ENABLE, 32'h2);
    rchk("enable bit1", uotg_pkg::ADDR_ENABLE, 32'h0);
    bus(1'b1, uotg_pkg::ADDR_STATUS, 32'hffff_ffff);
    rchk("status written", uotg_pkg::ADDR_STATUS, 32'h84);
    rchk("unmapped", 4'h2, 32'h0);
  endtask

  // both cable states with vbus levels 0 to 2; the ordered levels keep the pins legal
  task automatic t_status();
    logic [31:0] exp;
    for (int c = 0; c < 2; c++) begin
      for (int v = 0; v < 3; v++) begin
        cable_a <= c[0];
        vbus <= v[1:0];
        tick(4);
        exp = {24'h0, ~c[0], 3'h0, v != 0, v == 0, 1'b0, v == 2};
        rchk("status live", uotg_pkg::ADDR_STATUS, exp);
      end
    end
  endtask

  // one stimulus at a time with only the tested flag enabled; each vbus step also moves other flags
  task automatic t_irq();
    int b;
    bus(1'b1, uotg_pkg::ADDR_IRQ_MASK, 32'hfd);
    cable_a <= 1'b0;
    vbus <= 2'h0;
    tick(6);
    for (int i = 0; i < 5; i++) begin
      b = bits[i];
      bus(1'b1, uotg_pkg::ADDR_FLAGS, 32'hff);
      bus(1'b1, uotg_pkg::ADDR_ENABLE, 32'h1 << b);
      tick(4);
      chk("irq idle", 32'h0, {31'h0, irq});
      case (i)
        0: cable_a <= 1'b1;
        1: vbus <= 2'h1;
        2: vbus <= 2'h0;
        3: vbus <= 2'h2;
        default: act <= 1'b1;
      endcase
      tick(3);
      act <= 1'b0;
      tick(6);
      chk("irq raised", 32'h1, {31'h0, irq});
      bus(1'b1, uotg_pkg::ADDR_ENABLE, 32'h0);
      tick(3);
      chk("irq gated", 32'h0, {31'h0, irq});
      bus(1'b0, uotg_pkg::ADDR_FLAGS, 32'h0);
      chk("flag set", 32'h1, {31'h0, q[b]});
      bus(1'b1, uotg_pkg::ADDR_FLAGS, 32'h1 << b);
      bus(1'b0, uotg_pkg::ADDR_FLAGS, 32'h0);
      chk("flag cleared", 32'h0, {31'h0, q[b]});
    end
  endtask

  // the one long wait of the run: a full millisecond of quiet line state
  task automatic t_line();
    bus(1'b1, uotg_pkg::ADDR_ENABLE, 32'h0);
    cable_a <= 1'b0;
    vbus <= 2'h0;
    jst <= 1'b0;
    tick(100);
    rchk("status unstable", uotg_pkg::ADDR_STATUS, 32'h84);
    bus(1'b1, uotg_pkg::ADDR_FLAGS, 32'hff);
    bus(1'b1, uotg_pkg::ADDR_ENABLE, 32'h40);
    tick(50010);
    chk("irq ms timer", 32'h1, {31'h0, irq});
    rchk("status stable", uotg_pkg::ADDR_STATUS, 32'ha4);
    bus(1'b0, uotg_pkg::ADDR_FLAGS, 32'h0);
    chk("stable and ms flags", 32'h3, {30'h0, q[6:5]});
    bus(1'b1, uotg_pkg::ADDR_FLAGS, 32'h40);
    bus(1'b1, uotg_pkg::ADDR_ENABLE, 32'h20);
    tick(3);
    chk("irq line stable", 32'h1, {31'h0, irq});
    se0 <= 1'b1;
    tick(5);
    rchk("status moved", uotg_pkg::ADDR_STATUS, 32'h84);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    tick(4);
    arst_n_i <= 1'b1;
    t_reset();
    t_access();
    t_status();
    t_irq();
    t_line();
    give_verdict();
  end
endmodule // uotg_regs_tb
